// [ofgt_trim_regs.sv]
// Offset and fine-gain trim register bank with APB slave and trim outputs.
// Assumes input selects and the calibration flag come from another domain.
`timescale 1ns/100ps
module ofgt_trim_regs (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Converter status, asynchronous
    input  wire logic        core2_sel_b,
    input  wire logic        core3_sel_d,
    input  wire logic        offset_cal_active,
    // Trim values in effect
    output logic      [11:0] core2_offset,
    output logic      [11:0] core3_offset,
    output logic      [11:0] core4_offset,
    output logic      [11:0] core5_offset,
    output logic      [4:0]  core0_gain,
    output logic      [4:0]  core1_gain,
    output logic      [4:0]  core2_gain,
    output logic             trims_loaded
);
    import ofgt_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    ofgt_state_t        state;
    logic [3:0]         load_slot;
    logic [15:0]        fuse_data;
    logic [15:0]        trim [0:NUM_TRIM-1];
    logic [2:0]         sync_q1;
    logic [2:0]         sync_q2;
    logic               sel_b;
    logic               sel_d;
    logic               cal_busy;
    logic               access;
    logic               hit;
    logic [3:0]         slot;
    logic               is_offset;
    logic               refuse;
    logic               do_write;
    logic [15:0]        wr_mask;
    logic [15:0]        wr_value;

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    // Two flops for each asynchronous level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_q1 <= 3'h0;
            sync_q2 <= 3'h0;
        end else begin
            sync_q1 <= {offset_cal_active, core3_sel_d, core2_sel_b};
            sync_q2 <= sync_q1;
        end
    end

    assign sel_b    = sync_q2[0];
    assign sel_d    = sync_q2[1];
    assign cal_busy = sync_q2[2];

    // ************************************************************
    // Fuse default copy
    // ************************************************************
    ofgt_fuse_rom u_fuse (
        .pclk    (pclk),
        .presetn (presetn),
        .rd_slot (load_slot),
        .rd_data (fuse_data)
    );

    // Step through every slot once after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= OFGT_FETCH;
            load_slot <= SLOT_C2A;
        end else begin
            case (state)
                OFGT_FETCH: begin
                    state <= OFGT_STORE;
                end
                OFGT_STORE: begin
                    if (load_slot == SLOT_LAST) begin
                        state <= OFGT_READY;
                    end else begin
                        state     <= OFGT_FETCH;
                        load_slot <= load_slot + 4'h1;
                    end
                end
                OFGT_READY: begin
                    state <= OFGT_READY;
                end
                default: begin
                    state     <= OFGT_FETCH;
                    load_slot <= SLOT_C2A;
                end
            endcase
        end
    end

    // ************************************************************
    // Address decode
    // ************************************************************
    // Map the word index onto a storage slot
    always_comb begin
        hit  = 1'b0;
        slot = SLOT_C2A;
        for (int i = 0; i < NUM_TRIM; i++) begin
            if (paddr[11:2] == TRIM_INDEX[i] && paddr[1:0] == 2'h0) begin
                hit  = 1'b1;
                slot = 4'(i);
            end
        end
    end

    assign access    = psel && penable;
    assign is_offset = slot <= SLOT_C5;
    assign refuse    = hit && is_offset && cal_busy;
    assign do_write  = access && pready && pwrite && hit && !pslverr;
    assign wr_mask   = {{8{pstrb[1]}}, {8{pstrb[0]}}} & (is_offset ? OFFSET_REG_MASK : GAIN_REG_MASK);
    assign wr_value  = (trim[slot] & ~wr_mask) | (pwdata[15:0] & wr_mask);

    // ************************************************************
    // APB answer, one wait state, held off during fuse copy
    // ************************************************************
    // Registered answer, one edge after the access phase starts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (access && !pready && state == OFGT_READY) begin
            pready  <= 1'b1;
            pslverr <= !hit || refuse;
            prdata  <= (hit && !refuse && !pwrite) ? {16'h0000, trim[slot]} : 32'h0000_0000;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
    end

    // ************************************************************
    // Trim storage
    // ************************************************************
    // Fuse copy first, then software writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_TRIM; i++) begin
                trim[i] <= TRIM_RESET;
            end
        end else if (state == OFGT_STORE) begin
            trim[load_slot] <= fuse_data;
        end else if (do_write) begin
            trim[slot] <= wr_value;
        end
    end

    // ************************************************************
    // Trim outputs
    // ************************************************************
    // Pick the pair of the selected input, fields only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core2_offset <= 12'h000;
            core3_offset <= 12'h000;
            core4_offset <= 12'h000;
            core5_offset <= 12'h000;
            core0_gain   <= 5'h00;
            core1_gain   <= 5'h00;
            core2_gain   <= 5'h00;
            trims_loaded <= 1'b0;
        end else begin
            core2_offset <= sel_b ? trim[SLOT_C2B][OFFSET_MSB:0] : trim[SLOT_C2A][OFFSET_MSB:0];
            core3_offset <= sel_d ? trim[SLOT_C3D][OFFSET_MSB:0] : trim[SLOT_C3C][OFFSET_MSB:0];
            core4_offset <= trim[SLOT_C4][OFFSET_MSB:0];
            core5_offset <= trim[SLOT_C5][OFFSET_MSB:0];
            core0_gain   <= trim[SLOT_G0][GAIN_MSB:0];
            core1_gain   <= trim[SLOT_G1][GAIN_MSB:0];
            core2_gain   <= sel_b ? trim[SLOT_G2B][GAIN_MSB:0] : trim[SLOT_G2A][GAIN_MSB:0];
            trims_loaded <= state == OFGT_READY;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    // Bound on the fuse copy, in cycles
    localparam int LOAD_BOUND = FUSE_LOAD_MAX;

    // Bus held off until the copy is done
    a_load_holds_ready: assert property (@(posedge pclk) disable iff (!presetn)
        state != OFGT_READY |-> !pready)
        else $error("pready seen during fuse copy");

    a_load_time_bound: assert property (@(posedge pclk) disable iff (!presetn)
        state == OFGT_FETCH && load_slot == SLOT_C2A |-> ##[1:LOAD_BOUND] state == OFGT_READY)
        else $error("fuse copy too long");

    a_core2_pair_b: assert property (@(posedge pclk) disable iff (!presetn)
        sel_b |=> core2_offset == $past(trim[SLOT_C2B][11:0]) && core2_gain == $past(trim[SLOT_G2B][4:0]))
        else $error("core two input B pair not applied");

    a_core3_pair_c: assert property (@(posedge pclk) disable iff (!presetn)
        !sel_d |=> core3_offset == $past(trim[SLOT_C3C][11:0]))
        else $error("core three input C offset not applied");

    a_core2_gain_a: assert property (@(posedge pclk) disable iff (!presetn)
        !sel_b |=> core2_gain == $past(trim[SLOT_G2A][4:0]))
        else $error("core two input A gain not applied");

    a_sel_switch_pair: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(core2_sel_b) |-> ##3 core2_offset == $past(trim[SLOT_C2B][11:0]))
        else $error("select change not followed");

    a_write_applies: assert property (@(posedge pclk) disable iff (!presetn)
        do_write && slot == SLOT_C4 && pstrb[1:0] == 2'h3 |-> ##2 core4_offset == $past(pwdata[11:0], 2))
        else $error("written trim not in effect");

    a_read_returns: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pready && !pwrite && hit && !refuse && state == OFGT_READY
        |=> pready && !pslverr && prdata[15:0] == $past(trim[slot]))
        else $error("read data wrong");

    a_gain_fields: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> core0_gain == $past(trim[SLOT_G0][4:0]) && core1_gain == $past(trim[SLOT_G1][4:0]))
        else $error("gain field not applied");

    a_cal_refused: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pready && refuse && state == OFGT_READY |=> pready && pslverr && prdata == 32'h0)
        else $error("offset access during calibration not refused");

    a_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pready && !hit && state == OFGT_READY |=> pready && pslverr)
        else $error("unmapped address not flagged");

    a_misaligned_error: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pready && paddr[1:0] != 2'h0 && state == OFGT_READY |=> pready && pslverr)
        else $error("misaligned address not flagged");

    a_gain_never_refused: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pready && hit && !is_offset && state == OFGT_READY |=> pready && !pslverr)
        else $error("gain access refused");

    // Remaining pairs and single offsets follow storage
    a_core2_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
        !sel_b |=> core2_offset == $past(trim[SLOT_C2A][11:0]))
        else $error("core two input A offset not applied");

    a_core3_pair_d: assert property (@(posedge pclk) disable iff (!presetn)
        sel_d |=> core3_offset == $past(trim[SLOT_C3D][11:0]))
        else $error("core three input D offset not applied");

    a_single_offsets: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> core4_offset == $past(trim[SLOT_C4][11:0]) && core5_offset == $past(trim[SLOT_C5][11:0]))
        else $error("core four or five offset not applied");

    a_sel_switch_d: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(core3_sel_d) |-> ##3 core3_offset == $past(trim[SLOT_C3D][11:0]))
        else $error("core three select change not followed");

    // Fuse copy and bus answer shape
    a_fuse_copy_store: assert property (@(posedge pclk) disable iff (!presetn)
        state == OFGT_STORE && load_slot == SLOT_C4 |=> trim[SLOT_C4] == $past(fuse_data))
        else $error("fuse default not stored");

    a_answer_single: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("answer longer than one cycle");

    a_read_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
        pready |-> prdata[31:16] == 16'h0000)
        else $error("read data upper half not zero");

    a_refused_no_store: assert property (@(posedge pclk) disable iff (!presetn)
        access && pready && pslverr && slot == SLOT_C4 |=> trim[SLOT_C4] == $past(trim[SLOT_C4]))
        else $error("refused write changed storage");

    c_load_done: cover property (@(posedge pclk) disable iff (!presetn) $rose(trims_loaded));
    c_write_done: cover property (@(posedge pclk) disable iff (!presetn) do_write);
    c_read_done: cover property (@(posedge pclk) disable iff (!presetn) pready && !pwrite && !pslverr);
    c_sel_switch: cover property (@(posedge pclk) disable iff (!presetn) $rose(sel_b) ##2 $fell(sel_b));
    c_refused: cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr && hit);
endmodule

// [ofgt_pkg.sv]
// Package for the core offset and fine-gain trim register bank.
// Assumes an APB slave with 32-bit data and a 12-bit byte address.
package ofgt_pkg;

    // ************************************************************
    // Register indices, byte address is four times the index
    // ************************************************************
    localparam logic [9:0] IDX_CORE2_INPUT_A_OFFSET_TRIM    = 10'h334;
    localparam logic [9:0] IDX_CORE2_INPUT_B_OFFSET_TRIM    = 10'h336;
    localparam logic [9:0] IDX_CORE3_INPUT_C_OFFSET_TRIM    = 10'h338;
    localparam logic [9:0] IDX_CORE3_INPUT_D_OFFSET_TRIM    = 10'h33A;
    localparam logic [9:0] IDX_CORE4_OFFSET_TRIM            = 10'h33C;
    localparam logic [9:0] IDX_CORE5_OFFSET_TRIM            = 10'h33E;
    localparam logic [9:0] IDX_CORE0_FINE_GAIN_TRIM         = 10'h360;
    localparam logic [9:0] IDX_CORE1_FINE_GAIN_TRIM         = 10'h361;
    localparam logic [9:0] IDX_CORE2_INPUT_A_FINE_GAIN_TRIM = 10'h362;
    localparam logic [9:0] IDX_CORE2_INPUT_B_FINE_GAIN_TRIM = 10'h363;

    // ************************************************************
    // Storage slots
    // ************************************************************
    localparam int          NUM_TRIM   = 10;
    localparam int          NUM_OFFSET = 6;
    localparam logic [3:0]  SLOT_C2A   = 4'h0;
    localparam logic [3:0]  SLOT_C2B   = 4'h1;
    localparam logic [3:0]  SLOT_C3C   = 4'h2;
    localparam logic [3:0]  SLOT_C3D   = 4'h3;
    localparam logic [3:0]  SLOT_C4    = 4'h4;
    localparam logic [3:0]  SLOT_C5    = 4'h5;
    localparam logic [3:0]  SLOT_G0    = 4'h6;
    localparam logic [3:0]  SLOT_G1    = 4'h7;
    localparam logic [3:0]  SLOT_G2A   = 4'h8;
    localparam logic [3:0]  SLOT_G2B   = 4'h9;
    localparam logic [3:0]  SLOT_LAST  = 4'h9;

    localparam logic [9:0] TRIM_INDEX [0:9] = '{
        IDX_CORE2_INPUT_A_OFFSET_TRIM, IDX_CORE2_INPUT_B_OFFSET_TRIM,
        IDX_CORE3_INPUT_C_OFFSET_TRIM, IDX_CORE3_INPUT_D_OFFSET_TRIM,
        IDX_CORE4_OFFSET_TRIM,         IDX_CORE5_OFFSET_TRIM,
        IDX_CORE0_FINE_GAIN_TRIM,      IDX_CORE1_FINE_GAIN_TRIM,
        IDX_CORE2_INPUT_A_FINE_GAIN_TRIM, IDX_CORE2_INPUT_B_FINE_GAIN_TRIM};

    // ************************************************************
    // Field layouts and reset values
    // ************************************************************
    localparam int          OFFSET_MSB     = 11;
    localparam int          GAIN_MSB       = 4;
    localparam logic [15:0] OFFSET_REG_MASK = 16'hFFFF;
    localparam logic [15:0] GAIN_REG_MASK   = 16'h00FF;
    localparam logic [15:0] TRIM_RESET      = 16'h0000;

    // Fuse storage contents, values arbitrary
    localparam logic [15:0] FUSE_DEFAULT [0:9] = '{
        16'h0800, 16'h0800, 16'h0800, 16'h0800, 16'h0800,
        16'h0800, 16'h0010, 16'h0010, 16'h0010, 16'h0010};

    // Worst-case cycles for the fuse copy after reset
    localparam int          FUSE_LOAD_MAX = 24;

    // Fuse copy sequencer
    typedef enum logic [2:0] {
        OFGT_FETCH = 3'b001,
        OFGT_STORE = 3'b010,
        OFGT_READY = 3'b100
    } ofgt_state_t;

endpackage

// [ofgt_fuse_rom.sv]
// Fuse storage holding the power-up trim defaults.
// Assumes one clock; read data appear one edge after the address.
`timescale 1ns/100ps
module ofgt_fuse_rom (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Read port
    input  wire logic [3:0]  rd_slot,
    output logic      [15:0] rd_data
);
    import ofgt_pkg::*;

    // ************************************************************
    // Registered lookup
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data <= TRIM_RESET;
        end else if (rd_slot <= SLOT_LAST) begin
            rd_data <= FUSE_DEFAULT[rd_slot];
        end else begin
            rd_data <= TRIM_RESET;
        end
    end
endmodule

// [ofgt_trim_regs_test.sv]
// Self-checking testbench for the offset and fine-gain trim register bank.
// Assumes ofgt_pkg is compiled first; drives APB, selects and the calibration flag.
`timescale 1ns/100ps
module ofgt_trim_regs_test;
    import ofgt_pkg::*;

    // ************************************************************
    // Signals
    // ************************************************************
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        core2_sel_b;
    logic        core3_sel_d;
    logic        offset_cal_active;
    logic [11:0] core2_offset;
    logic [11:0] core3_offset;
    logic [11:0] core4_offset;
    logic [11:0] core5_offset;
    logic [4:0]  core0_gain;
    logic [4:0]  core1_gain;
    logic [4:0]  core2_gain;
    logic        trims_loaded;
    logic [15:0] cur [0:9];
    int          bad_count;
    int          checked;

    // ************************************************************
    // Design under test
    // ************************************************************
    ofgt_trim_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .core2_sel_b(core2_sel_b), .core3_sel_d(core3_sel_d),
        .offset_cal_active(offset_cal_active), .core2_offset(core2_offset),
        .core3_offset(core3_offset), .core4_offset(core4_offset), .core5_offset(core5_offset),
        .core0_gain(core0_gain), .core1_gain(core1_gain), .core2_gain(core2_gain),
        .trims_loaded(trims_loaded));

    // Clock, 20 ns period
    always #10 pclk = ~pclk;

    // ************************************************************
    // Tasks
    // ************************************************************
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 60);
        rd = prdata;
        err = pslverr;
        check(32'(pready), 32'h1, "answer");
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Access one slot and compare data and error flag
    task automatic access(input logic wr, input int s, input logic [15:0] v, input logic exp_err);
        logic [31:0] rd;
        logic        err;
        apb(wr, {TRIM_INDEX[s], 2'b00}, 32'(v), rd, err);
        check(32'(err), 32'(exp_err), "error flag");
        if (!wr) check(rd, exp_err ? 32'h0 : 32'(v), "read data");
    endtask

    // Let selects and stores reach the trim outputs
    task automatic settle;
        repeat (4) @(posedge pclk);
        #1;
    endtask

    // Trim outputs against the expected register contents
    task automatic check_outs;
        check(32'(core2_offset), 32'(cur[core2_sel_b ? 1 : 0][11:0]), "core2 offset");
        check(32'(core3_offset), 32'(cur[core3_sel_d ? 3 : 2][11:0]), "core3 offset");
        check(32'(core4_offset), 32'(cur[4][11:0]), "core4 offset");
        check(32'(core5_offset), 32'(cur[5][11:0]), "core5 offset");
        check(32'(core0_gain), 32'(cur[6][4:0]), "core0 gain");
        check(32'(core1_gain), 32'(cur[7][4:0]), "core1 gain");
        check(32'(core2_gain), 32'(cur[core2_sel_b ? 9 : 8][4:0]), "core2 gain");
    endtask

    // Reset pulse, then wait for the fuse copy
    task automatic do_reset(input int len);
        int n;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (len) @(posedge pclk);
        #1;
        check(32'(trims_loaded), 32'h0, "loaded in reset");
        check(32'(core4_offset), 32'h0, "offset in reset");
        @(posedge pclk);
        presetn <= 1'b1;
        access(1'b0, 0, FUSE_DEFAULT[0], 1'b0);
        n = 0;
        while (trims_loaded !== 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        check(32'(trims_loaded), 32'h1, "fuse copy");
        cur = FUSE_DEFAULT;
        settle();
        check_outs();
        for (int s = 0; s < NUM_TRIM; s++) access(1'b0, s, cur[s], 1'b0);
    endtask

    // Closing report and verdict
    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        logic [31:0] rd;
        logic        err;
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        core2_sel_b = 1'b0;
        core3_sel_d = 1'b0;
        offset_cal_active = 1'b0;
        bad_count = 0;
        checked = 0;
        do_reset(14);
        $display("test fuse defaults done");
        // Distinct values into every slot, both select settings
        for (int s = 0; s < NUM_TRIM; s++) begin
            cur[s] = (s < NUM_OFFSET) ? 16'h0A00 + 16'(s) * 16'h0111 : 16'(s * 3);
            access(1'b1, s, cur[s], 1'b0);
        end
        settle();
        check_outs();
        for (int s = 0; s < NUM_TRIM; s++) access(1'b0, s, cur[s], 1'b0);
        core2_sel_b <= 1'b1;
        core3_sel_d <= 1'b1;
        settle();
        check_outs();
        $display("test write and select done");
        // Unmapped index and misaligned byte address
        apb(1'b0, {10'h335, 2'b00}, 32'h0, rd, err);
        check(32'(err), 32'h1, "unmapped error");
        check(rd, 32'h0, "unmapped data");
        apb(1'b1, {IDX_CORE0_FINE_GAIN_TRIM, 2'b01}, 32'h1, rd, err);
        check(32'(err), 32'h1, "misaligned error");
        access(1'b0, 6, cur[6], 1'b0);
        $display("test unmapped done");
        // Low byte strobe only, upper byte of the register kept
        pstrb <= 4'h1;
        cur[5] = {cur[5][15:8], 8'hBC};
        access(1'b1, 5, 16'h00BC, 1'b0);
        pstrb <= 4'hF;
        access(1'b0, 5, cur[5], 1'b0);
        $display("test byte strobe done");
        // Offset access refused during calibration, gains still open
        offset_cal_active <= 1'b1;
        settle();
        access(1'b1, 4, 16'h0123, 1'b1);
        access(1'b0, 4, 16'h0000, 1'b1);
        cur[6] = 16'h001F;
        access(1'b1, 6, cur[6], 1'b0);
        offset_cal_active <= 1'b0;
        settle();
        access(1'b0, 4, cur[4], 1'b0);
        check_outs();
        $display("test calibration done");
        // Second reset in mid-run restores fuse defaults
        do_reset(2);
        $display("test second reset done");
        print_verdict();
    end

    // Watchdog
    initial begin
        #(20 * 8000);
        bad_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        print_verdict();
    end
endmodule
